// File: rtl/secure_cmd_engine.sv
// Summary of operation
// - Plain slots read openly, 4 or 32 bytes
// - Secret unencrypted slots refuse every read
// - Encrypted slots use read key, no 4-byte
// - Encrypted read needs valid digest-origin matching key
// - Even slot needs random nonce origin
// - Odd slot origin must match MAC select
// - Encrypted data XORed with scratch key bytes
// - Hash opcode 0x47, second parameter zero
// - Hash init loads IV, fixed nonce flags
// - Hash compute folds 64 bytes, returns digest
// - Compute refused unless init ran first
// - Other command inside sequence returns error
// - Hash mode other than 0/1 parse error
// - Sleep or watchdog invalidates intermediate digest
// - Hash init answers one status byte
// - Spare update opcode 0x20, checked fields zero
// - Mode bit 1 decrements slot's use counter
// - No uses left errors, else clear one
// - Byte 84 written only while zero
// - Locked policy writes byte 85 once
// - Open policy always overwrites byte 85
`timescale 1ns/1ps
`default_nettype none

module secure_cmd_engine #(
  parameter int SLOTS     = 16,
  parameter int MSG_WORDS = 16,
  parameter int KEY_WORDS = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         sleep_i,
  input  wire logic         wdt_expire_i,
  output logic              mem_rd_o,
  output logic      [6:0]   mem_addr_o,
  input  wire logic [31:0]  mem_data_i,
  output logic              hash_start_o,
  output logic      [255:0] hash_state_o,
  output logic      [511:0] hash_block_o,
  input  wire logic         hash_done_i,
  input  wire logic [255:0] hash_digest_i,
  output logic              busy_o,
  output logic              done_o
);

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FETCH, S_HASH} state_t;

  state_t      state_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] cmd_reg;
  logic [7:0]  status_reg;
  logic [5:0]  len_reg;
  logic        busy_reg;
  logic        done_reg;
  logic        sha_active_reg;
  logic        valid_reg;
  logic        digest_reg;
  logic        nonce_reg;
  logic [3:0]  kslot_reg;
  logic [23:0] cfg_reg;
  logic [15:0] mac_sel_reg;
  logic [4:0]  use_ctl_reg;
  logic [31:0] use_bits_reg;
  logic        mem_rd_reg;
  logic [6:0]  mem_addr_reg;
  logic        rd_dly_reg;
  logic [3:0]  issue_reg;
  logic [3:0]  recv_reg;
  logic [3:0]  nwords_reg;
  logic        encrypt_reg;
  logic        hash_start_reg;
  logic [15:0] slot_cfg [SLOTS];
  logic [31:0] msg_mem  [MSG_WORDS];
  logic [31:0] key_mem  [KEY_WORDS];
  logic [31:0] res_mem  [KEY_WORDS];

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode; every write, the result page included, is refused while busy
  wire        bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        idle     = (state_reg == S_IDLE);
  wire        bus_wr   = bus_req & wb_we_i & idle;
  wire [1:0]  pg       = wb_adr_i[7:6];
  wire [3:0]  widx     = wb_adr_i[5:2];
  wire        wr_cmd   = bus_wr & (wb_adr_i == cmd_pkg::A_CMD);
  wire        wr_cfg   = bus_wr & (wb_adr_i == cmd_pkg::A_CFG);
  wire        wr_kfl   = bus_wr & (wb_adr_i == cmd_pkg::A_KFLAGS);
  wire        wr_mac   = bus_wr & (wb_adr_i == cmd_pkg::A_MACSEL);
  wire        wr_uctl  = bus_wr & (wb_adr_i == cmd_pkg::A_USECTL);
  wire        wr_ubits = bus_wr & (wb_adr_i == cmd_pkg::A_USEBITS);
  wire        wr_msg   = bus_wr & (pg == cmd_pkg::PG_MSG);
  wire        wr_key   = bus_wr & (pg == cmd_pkg::PG_KEY) & ~widx[3];
  wire        wr_slot  = bus_wr & (pg == cmd_pkg::PG_SLOT);
  wire [31:0] cfg_wr_word = merge({8'h0, cfg_reg}, wb_dat_i, wb_sel_i); // Top byte is not stored

  // Read data selection
  wire [31:0] status_word = {2'h0, len_reg, 7'h0, sha_active_reg, status_reg, 7'h0, busy_reg};
  wire [31:0] kflag_word  = {24'h0, kslot_reg, 1'b0, nonce_reg, digest_reg, valid_reg};
  wire [31:0] regs_word   = (wb_adr_i == cmd_pkg::A_CMD)     ? cmd_reg :
                            (wb_adr_i == cmd_pkg::A_STATUS)  ? status_word :
                            (wb_adr_i == cmd_pkg::A_CFG)     ? {8'h0, cfg_reg} :
                            (wb_adr_i == cmd_pkg::A_KFLAGS)  ? kflag_word :
                            (wb_adr_i == cmd_pkg::A_MACSEL)  ? {16'h0, mac_sel_reg} :
                            (wb_adr_i == cmd_pkg::A_USECTL)  ? {27'h0, use_ctl_reg} :
                            (wb_adr_i == cmd_pkg::A_USEBITS) ? use_bits_reg : 32'h0;
  wire [31:0] rd_word     = (pg == cmd_pkg::PG_REGS) ? regs_word :
                            (pg == cmd_pkg::PG_KEY)  ? (widx[3] ? 32'h0 : res_mem[widx[2:0]]) :
                            (pg == cmd_pkg::PG_SLOT) ? {16'h0, slot_cfg[widx]} : 32'h0;

  // Command fields
  wire [7:0]  op       = cmd_reg[7:0];
  wire [7:0]  mode     = cmd_reg[15:8];
  wire [15:0] arg      = cmd_reg[31:16];
  wire        is_sha   = (op == cmd_pkg::OP_SHA);
  wire        is_read  = (op == cmd_pkg::OP_READ);
  wire        is_spare = (op == cmd_pkg::OP_SPARE);
  wire        ex       = (state_reg == S_EXEC);
  wire [7:0]  cb19     = cfg_reg[cmd_pkg::CB19_LSB +: 8];
  wire [7:0]  cb84     = cfg_reg[cmd_pkg::CB84_LSB +: 8];
  wire [7:0]  cb85     = cfg_reg[cmd_pkg::CB85_LSB +: 8];

  // Parameter checks per command
  wire sha_bad  = (mode[7:1] != 7'h0) | (arg != 16'h0);
  wire sp_bad   = (mode[7:2] != 6'h0) | (arg[15:8] != 8'h0);
  wire rd_bad   = (mode[6:2] != 5'h0) | (mode[1:0] != cmd_pkg::ZONE_DATA);
  wire parse_er = is_sha ? sha_bad : is_read ? rd_bad : is_spare ? sp_bad : 1'b1;

  // Read permission for the addressed slot
  wire       is32    = mode[cmd_pkg::ZN_SIZE_BIT];
  wire [3:0] rd_slot = arg[6:3];
  wire       deny;
  wire       encrypt;

  read_gate read_gate_inst (
    .settings_i          (slot_cfg[rd_slot]),
    .slot_i              (rd_slot),
    .is32_i              (is32),
    .key_valid_i         (valid_reg),
    .digest_origin_i     (digest_reg),
    .nonce_origin_i      (nonce_reg),
    .key_slot_i          (kslot_reg),
    .mac_origin_select_i (mac_sel_reg[rd_slot]),
    .deny_o              (deny),
    .encrypt_o           (encrypt)
  );

  // Spare byte update outcome
  wire use_hit    = use_ctl_reg[4] & (use_ctl_reg[3:0] == arg[3:0]);
  wire spare_fail = mode[1] ? (use_hit & (use_bits_reg == 32'h0)) :
                    ~mode[0] ? (cb84 != 8'h0) :
                    ((cb19 != 8'h0) & (cb85 != 8'h0));

  // Execution errors and the resulting code
  wire exec_er  = (sha_active_reg & ~is_sha)
                | (is_sha & mode[0] & ~sha_active_reg)
                | (is_read & deny)
                | (is_spare & spare_fail);
  wire ex_ok    = ~parse_er & ~exec_er;
  wire [7:0] ex_code = parse_er ? cmd_pkg::ST_PARSE : exec_er ? cmd_pkg::ST_EXEC : cmd_pkg::ST_OK;
  wire ex_read  = ex & ex_ok & is_read;
  wire ex_comp  = ex & ex_ok & is_sha & mode[0];
  wire ex_init  = ex & ex_ok & is_sha & ~mode[0];
  wire ex_spare = ex & ex_ok & is_spare;
  wire w84      = ex_spare & (mode[1:0] == 2'h0);
  wire w85      = ex_spare & ~mode[1] & mode[0];
  wire dec      = ex_spare & mode[1] & use_hit;

  // Completion of each flow
  wire capture  = (state_reg == S_FETCH) & rd_dly_reg;
  wire f_last   = capture & (recv_reg == nwords_reg - 4'h1);
  wire h_last   = (state_reg == S_HASH) & hash_done_i & ~hash_start_reg;
  wire finish   = (ex & ~ex_read & ~ex_comp) | f_last | h_last;
  wire [5:0] fin_len = ex ? cmd_pkg::LEN_STATUS :
                       (f_last & (nwords_reg == cmd_pkg::WORDS_SHORT)) ? cmd_pkg::LEN_WORD :
                       cmd_pkg::LEN_BLOCK;
  wire kill     = sleep_i | wdt_expire_i;

  // Wishbone answer, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else if (ce_i) begin
      ack_reg <= bus_req;
      dat_reg <= bus_req ? rd_word : dat_reg;
    end
  end

  // Command sequencing and status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= S_IDLE;
      cmd_reg    <= 32'h0;
      status_reg <= cmd_pkg::ST_OK;
      len_reg    <= 6'h0;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
    end else if (ce_i) begin
      done_reg <= finish;
      if (wr_cmd) begin
        cmd_reg   <= merge(cmd_reg, wb_dat_i, wb_sel_i);
        state_reg <= S_EXEC;
        busy_reg  <= 1'b1;
      end else if (finish) begin
        state_reg  <= S_IDLE;
        busy_reg   <= 1'b0;
        status_reg <= ex ? ex_code : cmd_pkg::ST_OK;
        len_reg    <= fin_len;
      end else if (ex_read) begin
        state_reg <= S_FETCH;
      end else if (ex_comp) begin
        state_reg <= S_HASH;
      end
    end
  end

  // Scratch key flags and hash sequence tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sha_active_reg <= 1'b0;
      valid_reg      <= 1'b0;
      digest_reg     <= 1'b0;
      nonce_reg      <= 1'b0;
      kslot_reg      <= 4'h0;
    end else if (ce_i) begin
      if (kill) begin
        sha_active_reg <= 1'b0;
        valid_reg      <= 1'b0;
      end else if (ex_init) begin
        sha_active_reg <= 1'b1;
        valid_reg      <= 1'b1;
        digest_reg     <= 1'b0;
        nonce_reg      <= 1'b0;
      end else if (ex & ~is_sha) begin
        sha_active_reg <= 1'b0;
      end else if (wr_kfl) begin
        valid_reg  <= wb_dat_i[0];
        digest_reg <= wb_dat_i[1];
        nonce_reg  <= wb_dat_i[2];
        kslot_reg  <= wb_dat_i[7:4];
      end
    end
  end

  // Configuration bytes and limited-use counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg      <= 24'h0;
      mac_sel_reg  <= 16'h0;
      use_ctl_reg  <= 5'h0;
      use_bits_reg <= 32'h0;
    end else if (ce_i) begin
      if (w84) cfg_reg[cmd_pkg::CB84_LSB +: 8] <= arg[7:0];
      else if (w85) cfg_reg[cmd_pkg::CB85_LSB +: 8] <= arg[7:0];
      else if (wr_cfg) cfg_reg <= cfg_wr_word[23:0];
      if (dec) use_bits_reg <= use_bits_reg & (use_bits_reg - 32'h1);
      else if (wr_ubits) use_bits_reg <= merge(use_bits_reg, wb_dat_i, wb_sel_i);
      if (wr_mac) mac_sel_reg <= wb_dat_i[15:0];
      if (wr_uctl) use_ctl_reg <= wb_dat_i[4:0];
    end
  end

  // Memory fetch for data-zone reads, one word per cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_reg   <= 1'b0;
      mem_addr_reg <= 7'h0;
      rd_dly_reg   <= 1'b0;
      issue_reg    <= 4'h0;
      recv_reg     <= 4'h0;
      nwords_reg   <= 4'h0;
      encrypt_reg  <= 1'b0;
    end else if (ce_i) begin
      rd_dly_reg <= mem_rd_reg;
      if (ex_read) begin
        nwords_reg   <= is32 ? cmd_pkg::WORDS_LONG : cmd_pkg::WORDS_SHORT;
        mem_addr_reg <= {rd_slot, is32 ? 3'h0 : arg[2:0]};
        issue_reg    <= 4'h0;
        recv_reg     <= 4'h0;
        encrypt_reg  <= encrypt;
      end else if ((state_reg == S_FETCH) & (issue_reg != nwords_reg)) begin
        mem_rd_reg   <= 1'b1;
        issue_reg    <= issue_reg + 4'h1;
        mem_addr_reg <= (issue_reg == 4'h0) ? mem_addr_reg : mem_addr_reg + 7'h1;
      end else begin
        mem_rd_reg <= 1'b0;
      end
      if (capture) recv_reg <= recv_reg + 4'h1;
    end
  end

  // Hash start pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) hash_start_reg <= 1'b0;
    else if (ce_i) hash_start_reg <= ex_comp;
  end

  // Key, result and message storage
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      for (int i = 0; i < KEY_WORDS; i++) begin
        if (ex_init) key_mem[i] <= cmd_pkg::SHA_IV[255-32*i -: 32];
        else if (h_last) key_mem[i] <= hash_digest_i[255-32*i -: 32];
        else if (wr_key & (widx[2:0] == i[2:0])) key_mem[i] <= merge(key_mem[i], wb_dat_i, wb_sel_i);
        if (h_last) res_mem[i] <= hash_digest_i[255-32*i -: 32];
        else if (capture & (recv_reg[2:0] == i[2:0]))
          res_mem[i] <= mem_data_i ^ (encrypt_reg ? key_mem[i] : 32'h0);
      end
      for (int m = 0; m < MSG_WORDS; m++) begin
        if (wr_msg & (widx == m[3:0])) msg_mem[m] <= merge(msg_mem[m], wb_dat_i, wb_sel_i);
      end
      for (int s = 0; s < SLOTS; s++) begin
        if (wr_slot & (widx == s[3:0])) slot_cfg[s] <= wb_dat_i[15:0];
      end
    end
  end

  // Flattened hash core ports
  genvar g;
  generate
    for (g = 0; g < KEY_WORDS; g++) begin : g_state
      assign hash_state_o[255-32*g -: 32] = key_mem[g];
    end
    for (g = 0; g < MSG_WORDS; g++) begin : g_block
      assign hash_block_o[511-32*g -: 32] = msg_mem[g];
    end
  endgenerate

  // Outputs
  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = dat_reg;
  assign mem_rd_o     = mem_rd_reg;
  assign mem_addr_o   = mem_addr_reg;
  assign hash_start_o = hash_start_reg;
  assign busy_o       = busy_reg;
  assign done_o       = done_reg;

  // Checks next to the logic they guard
  wire rd_plain = ~slot_cfg[rd_slot][cmd_pkg::SS_SECRET] & ~slot_cfg[rd_slot][cmd_pkg::SS_ENCRD];
  wire rd_ok_fl = ex & is_read & ~rd_bad & ~sha_active_reg;

  a_plain_read_go: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & rd_ok_fl & rd_plain) |=> (state_reg == S_FETCH)) else $error("plain read not started");
  a_secret_read_deny: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & rd_ok_fl & slot_cfg[rd_slot][cmd_pkg::SS_SECRET] & ~slot_cfg[rd_slot][cmd_pkg::SS_ENCRD])
    |=> (status_reg == cmd_pkg::ST_EXEC) && (state_reg == S_IDLE)) else $error("secret slot was read");
  a_enc_short_deny: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & rd_ok_fl & slot_cfg[rd_slot][cmd_pkg::SS_ENCRD] & ~is32)
    |=> (status_reg == cmd_pkg::ST_EXEC) ##1 !mem_rd_o) else $error("short encrypted read allowed");
  a_key_flag_deny: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & rd_ok_fl & slot_cfg[rd_slot][cmd_pkg::SS_ENCRD] & ~valid_reg)
    |=> (status_reg == cmd_pkg::ST_EXEC)) else $error("invalid key used for read");
  a_sha_init_load: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & ex_init & ~kill) |=> valid_reg && !digest_reg && (hash_state_o == cmd_pkg::SHA_IV)
    && (len_reg == cmd_pkg::LEN_STATUS)) else $error("hash init did not load state");
  a_compute_needs_init: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & ex & is_sha & ~sha_bad & mode[0] & ~sha_active_reg)
    |=> (status_reg == cmd_pkg::ST_EXEC) ##1 !hash_start_o) else $error("compute ran without init");
  a_sha_mode_parse: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & ex & is_sha & (mode[7:1] != 7'h0)) |=> (status_reg == cmd_pkg::ST_PARSE))
    else $error("bad hash mode accepted");
  a_sleep_kills_key: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & kill) |=> !valid_reg && !sha_active_reg) else $error("digest survived sleep");
  a_spare_84_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i & ex & is_spare & ~sp_bad & ~sha_active_reg & (mode[1:0] == 2'h0) & (cb84 != 8'h0))
    |=> $stable(cfg_reg[cmd_pkg::CB84_LSB +: 8]) && (status_reg == cmd_pkg::ST_EXEC))
    else $error("byte 84 overwritten");

endmodule

`default_nettype wire

// File: rtl/cmd_pkg.sv
package cmd_pkg;

  // Command opcodes
  localparam logic [7:0] OP_READ  = 8'h02;
  localparam logic [7:0] OP_SHA   = 8'h47;
  localparam logic [7:0] OP_SPARE = 8'h20;

  // Status codes returned by a command
  localparam logic [7:0] ST_OK    = 8'h00;
  localparam logic [7:0] ST_PARSE = 8'h03;
  localparam logic [7:0] ST_EXEC  = 8'h0f;

  // Response lengths in bytes
  localparam logic [5:0] LEN_STATUS = 6'h01;
  localparam logic [5:0] LEN_WORD   = 6'h04;
  localparam logic [5:0] LEN_BLOCK  = 6'h20;

  // Word counts of a read
  localparam logic [3:0] WORDS_SHORT = 4'h1;
  localparam logic [3:0] WORDS_LONG  = 4'h8;

  // Register byte offsets in page zero
  localparam logic [7:0] A_CMD     = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_CFG     = 8'h08;
  localparam logic [7:0] A_KFLAGS  = 8'h0c;
  localparam logic [7:0] A_MACSEL  = 8'h10;
  localparam logic [7:0] A_USECTL  = 8'h14;
  localparam logic [7:0] A_USEBITS = 8'h18;

  // Pages selected by address bits 7:6
  localparam logic [1:0] PG_REGS = 2'h0;
  localparam logic [1:0] PG_MSG  = 2'h1;
  localparam logic [1:0] PG_KEY  = 2'h2;
  localparam logic [1:0] PG_SLOT = 2'h3;

  // Slot settings word fields
  localparam int SS_SECRET   = 7;
  localparam int SS_ENCRD    = 6;
  localparam int SS_RKEY_LSB = 0;

  // Read zone byte fields
  localparam int         ZN_SIZE_BIT = 7;
  localparam logic [1:0] ZONE_DATA   = 2'h2;

  // Configuration byte positions inside the CFG register
  localparam int CB19_LSB = 0;
  localparam int CB84_LSB = 8;
  localparam int CB85_LSB = 16;

  // SHA-256 initial hash value
  localparam logic [255:0] SHA_IV =
    256'h6a09e667bb67ae853c6ef372a54ff53a510e527f9b05688c1f83d9ab5be0cd19;

endpackage

// File: rtl/read_gate.sv
`timescale 1ns/1ps
`default_nettype none

module read_gate (
  input  wire logic [15:0] settings_i,
  input  wire logic [3:0]  slot_i,
  input  wire logic        is32_i,
  input  wire logic        key_valid_i,
  input  wire logic        digest_origin_i,
  input  wire logic        nonce_origin_i,
  input  wire logic [3:0]  key_slot_i,
  input  wire logic        mac_origin_select_i,
  output logic             deny_o,
  output logic             encrypt_o
);

  logic       secret_slot_flag;
  logic       encrypted_read_flag;
  logic [3:0] read_key_slot_field;
  logic       key_ok;
  logic       origin_ok;

  // Field extraction from the slot settings word
  assign secret_slot_flag    = settings_i[cmd_pkg::SS_SECRET];
  assign encrypted_read_flag = settings_i[cmd_pkg::SS_ENCRD];
  assign read_key_slot_field = settings_i[cmd_pkg::SS_RKEY_LSB +: 4];

  // Scratch key must come from a digest over the read key slot
  assign key_ok = key_valid_i & digest_origin_i & (key_slot_i == read_key_slot_field);

  // Even slots need random origin, odd slots follow the MAC origin bit
  assign origin_ok = slot_i[0] ? (nonce_origin_i == mac_origin_select_i)
                               : nonce_origin_i;

  // Plain slots pass, secret plain slots never, encrypted need full checks
  assign deny_o = (secret_slot_flag & ~encrypted_read_flag)
                | (encrypted_read_flag & (~is32_i | ~key_ok | ~origin_ok));
  assign encrypt_o = encrypted_read_flag;

endmodule

`default_nettype wire

// File: bench/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
  input  wire logic         clk_i,
  input  wire logic         mem_rd_i,
  input  wire logic [6:0]   mem_addr_i,
  output logic      [31:0]  mem_data_o,
  input  wire logic         hash_start_i,
  input  wire logic [255:0] hash_state_i,
  input  wire logic [511:0] hash_block_i,
  output logic              hash_done_o,
  output logic      [255:0] hash_digest_o
);
  logic [2:0] cnt_reg = 3'h0;

  initial mem_data_o = 32'h0;
  initial hash_done_o = 1'b0;
  initial hash_digest_o = 256'h0;

  // Registered memory, word tagged by its address; scrambled between reads
  always @(posedge clk_i) begin
    mem_data_o <= mem_rd_i ? {25'h0a5a5a5, mem_addr_i} : ~mem_data_o;
  end

  // Slow stand-in core: state XOR first half of block, done four cycles on
  always @(posedge clk_i) begin
    hash_done_o <= (cnt_reg == 3'h1);
    cnt_reg <= hash_start_i ? 3'h4 : ((cnt_reg != 3'h0) ? cnt_reg - 3'h1 : cnt_reg);
    if (hash_start_i) hash_digest_o <= hash_state_i ^ hash_block_i[511:256];
    else if (hash_done_o) hash_digest_o <= ~hash_digest_o;
  end
endmodule

`default_nettype wire

// File: bench/secure_read_hash_extra_cmds_test.sv
`timescale 1ns/1ps
`default_nettype none

module secure_read_hash_extra_cmds_test;
  logic         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0, wdt = 1'b0;
  logic [7:0]   adr = 8'h00, c;
  logic [31:0]  dat = 32'h0, dout, mdat, q;
  logic         ack, mrd, hst, hdn, busy, done;
  logic [6:0]   madr;
  logic [255:0] hstate, hdig;
  logic [511:0] hblk;
  int           n_mismatch = 0, compares = 0;
  int           n_done = 0;

  always #10 clk_i = ~clk_i;

  // Count completion pulses, one expected per command
  always @(posedge clk_i) if (done === 1'b1) n_done <= n_done + 1;

  // Clock enable and byte enables tied on
  secure_cmd_engine secure_cmd_engine_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dout),
    .wb_ack_o(ack), .sleep_i(slp), .wdt_expire_i(wdt), .mem_rd_o(mrd), .mem_addr_o(madr), .mem_data_i(mdat),
    .hash_start_o(hst), .hash_state_o(hstate), .hash_block_o(hblk), .hash_done_i(hdn),
    .hash_digest_i(hdig), .busy_o(busy), .done_o(done));
  far_side_model far_side_model_inst (.clk_i(clk_i), .mem_rd_i(mrd), .mem_addr_i(madr), .mem_data_o(mdat),
    .hash_start_i(hst), .hash_state_i(hstate), .hash_block_i(hblk), .hash_done_o(hdn), .hash_digest_o(hdig));

  // Comparisons
  task chk(input logic [255:0] g, input logic [255:0] e);
    compares++;
    if (g !== e) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end
  endtask
  task chk_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin n_mismatch++; $display("ERROR %0t got %h exp %h", $time, g, e); end
  endtask

  // Classic Wishbone single cycle, waits for ack; only the watchdog ends a hang
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i) begin cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; end
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Launch a command and poll status until idle
  task cmd(input logic [7:0] op, input logic [7:0] md, input logic [15:0] p2);
    int d0;
    d0 = n_done;
    wb(1'b1, cmd_pkg::A_CMD, {p2, md, op});
    do wb(1'b0, cmd_pkg::A_STATUS, 32'h0); while (q[0] !== 1'b0);
    c = q[15:8];
    chk(n_done - d0, 256'h1);
    chk_bit(busy, 1'b0);
  endtask

  // Data-zone read with given slot settings and scratch key flags
  task t_read(input logic [3:0] s, input logic [7:0] zn, input logic [15:0] ss, input logic [7:0] kf,
              input logic ok, input logic xr);
    wb(1'b1, {2'h3, s, 2'h0}, {16'h0, ss});
    wb(1'b1, cmd_pkg::A_KFLAGS, {24'h0, kf});
    wb(1'b1, 8'h80, 32'h5a5a0ff0);
    cmd(cmd_pkg::OP_READ, zn, {9'h0, s, 3'h0});
    chk_bit(c === cmd_pkg::ST_OK, ok);
    wb(1'b0, 8'h80, 32'h0);
    if (ok) chk(q, {25'h0a5a5a5, s, 3'h0} ^ (xr ? 32'h5a5a0ff0 : 32'h0));
  endtask

  // Hash command: refusals, init, one compute block
  task t_sha;
    cmd(cmd_pkg::OP_SHA, 8'h01, 16'h0);
    chk_bit(c === cmd_pkg::ST_OK, 1'b0);
    cmd(cmd_pkg::OP_SHA, 8'h00, 16'h0001);
    chk_bit(c === cmd_pkg::ST_OK, 1'b0);
    cmd(cmd_pkg::OP_SHA, 8'h02, 16'h0);
    chk(c, cmd_pkg::ST_PARSE);
    cmd(cmd_pkg::OP_SHA, 8'h00, 16'h0);
    chk(c, cmd_pkg::ST_OK);
    chk(hstate, cmd_pkg::SHA_IV);
    for (int i = 0; i < 16; i++) wb(1'b1, 8'h40 + 8'(4 * i), (i == 15) ? 32'h180 : 32'h01000000 + i);
    cmd(cmd_pkg::OP_SHA, 8'h01, 16'h0);
    chk(c, cmd_pkg::ST_OK);
    wb(1'b0, 8'h80, 32'h0);
    chk(q, cmd_pkg::SHA_IV[255:224] ^ 32'h01000000);
    chk(hstate[31:0], cmd_pkg::SHA_IV[31:0] ^ 32'h01000007);
  endtask

  // Sequence broken by another command, watchdog, then sleep
  task t_break;
    for (int k = 0; k < 3; k++) begin
      cmd(cmd_pkg::OP_SHA, 8'h00, 16'h0);
      if (k == 0) begin cmd(cmd_pkg::OP_READ, 8'h82, 16'h0008); chk(c, cmd_pkg::ST_EXEC); end
      else begin @(posedge clk_i) {slp, wdt} <= k[1:0]; @(posedge clk_i) {slp, wdt} <= 2'b00; end
      cmd(cmd_pkg::OP_SHA, 8'h01, 16'h0);
      chk_bit(c === cmd_pkg::ST_OK, 1'b0);
    end
  endtask

  // Spare bytes and limited-use counter
  task t_spare;
    wb(1'b1, cmd_pkg::A_CFG, 32'h0);
    cmd(cmd_pkg::OP_SPARE, 8'h00, 16'h0011);
    chk(c, cmd_pkg::ST_OK);
    cmd(cmd_pkg::OP_SPARE, 8'h00, 16'h0022);
    chk(c, cmd_pkg::ST_EXEC);
    cmd(cmd_pkg::OP_SPARE, 8'h01, 16'h0033);
    cmd(cmd_pkg::OP_SPARE, 8'h01, 16'h0044);
    chk(c, cmd_pkg::ST_OK);
    cmd(cmd_pkg::OP_SPARE, 8'h04, 16'h0055);
    chk_bit(c === cmd_pkg::ST_OK, 1'b0);
    cmd(cmd_pkg::OP_SPARE, 8'h01, 16'h0155);
    chk_bit(c === cmd_pkg::ST_OK, 1'b0);
    wb(1'b0, cmd_pkg::A_CFG, 32'h0);
    chk(q[23:0], 24'h441100);
    wb(1'b1, cmd_pkg::A_CFG, 32'h00001101);
    cmd(cmd_pkg::OP_SPARE, 8'h01, 16'h0066);
    chk(c, cmd_pkg::ST_OK);
    cmd(cmd_pkg::OP_SPARE, 8'h01, 16'h0077);
    chk(c, cmd_pkg::ST_EXEC);
    wb(1'b0, cmd_pkg::A_CFG, 32'h0);
    chk(q[23:16], 8'h66);
    wb(1'b1, cmd_pkg::A_USECTL, 32'h13);
    wb(1'b1, cmd_pkg::A_USEBITS, 32'h3);
    cmd(cmd_pkg::OP_SPARE, 8'h03, 16'h0003);
    wb(1'b0, cmd_pkg::A_USEBITS, 32'h0);
    chk(q, 32'h2);
    cmd(cmd_pkg::OP_SPARE, 8'h02, 16'h0003);
    cmd(cmd_pkg::OP_SPARE, 8'h02, 16'h0003);
    chk_bit(c === cmd_pkg::ST_OK, 1'b0);
    cmd(cmd_pkg::OP_SPARE, 8'h02, 16'h0004);
    chk(c, cmd_pkg::ST_OK);
  endtask

  task complete_run;
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #400000;
    n_mismatch++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, cmd_pkg::A_MACSEL, 32'h0);
    t_read(4'h1, 8'h82, 16'h0000, 8'h00, 1'b1, 1'b0);
    t_read(4'h1, 8'h02, 16'h0000, 8'h00, 1'b1, 1'b0);
    t_read(4'h2, 8'h82, 16'h0080, 8'h57, 1'b0, 1'b0);
    t_read(4'h2, 8'h82, 16'h00c5, 8'h57, 1'b1, 1'b1);
    t_read(4'h2, 8'h02, 16'h00c5, 8'h57, 1'b0, 1'b0);
    t_read(4'h2, 8'h82, 16'h00c5, 8'h55, 1'b0, 1'b0);
    t_read(4'h2, 8'h82, 16'h00c5, 8'h67, 1'b0, 1'b0);
    t_read(4'h2, 8'h82, 16'h00c5, 8'h56, 1'b0, 1'b0);
    t_read(4'h2, 8'h82, 16'h00c5, 8'h53, 1'b0, 1'b0);
    t_read(4'h3, 8'h82, 16'h00c5, 8'h53, 1'b1, 1'b1);
    t_read(4'h3, 8'h82, 16'h00c5, 8'h57, 1'b0, 1'b0);
    t_sha();
    t_break();
    t_spare();
    complete_run();
  end
endmodule

`default_nettype wire
